// ===== core/irl_request_logic.sv
// Interrupt request logic: flags, enables, vectoring and sleep wake
// What this block does
// - Global enable bit 7 of control passes unmasked requests or blocks all.
// - The rst_n reset clears the global enable; porRst_n alone does not.
// - Return-from-interrupt sets the global enable again.
// - Accept clears global enable, pushes return address, vectors to 0004h.
// - Flags set on events regardless of any enable bit.
// - Vector two Tcy after Q1 acceptance; async pin events take the same path as synchronous ones.
// - After clearing global enable, next cycle is a NOP; requests wait.
// - External pin edge per edge-select sets the pin flag, bit 1.
// - Pin enable bit 4; enabled pin wakes, global enable decides vectoring.
// - Timer-0 rollover sets overflow flag bit 2; enable in bit 5.
// - Upper four port pins changing set flag bit 0, enabled by bit 3.
// - Pin change coinciding with a port read may be missed.
// - Pin flag may set any time; requests are sampled at Q1 while the sequencer is idle and no NOP is held.
// - Peripheral flags at 0Ch, enables at 8Ch, bit 3 unimplemented.
// - Only the return address is saved; no other context.
// - Non power-up resets clear control except the port-change flag.
// - Ten interrupt sources in total.
// - Enabled interrupt wakes sleep whatever the global enable.
// - Sleep acts as NOP if anything is enabled and pending.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "irl_regs.svh"

module irl_request_logic (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic porRst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire irl_pkg::irl_byte_t regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Interrupt sources
  input wire logic extIrqPin,
  input wire logic timer0Rollover,
  input wire logic [3:0] portUpperPins,
  input wire logic portRead,
  input wire logic [7:0] periphEvent,
  // Core sequencer
  input wire logic returnFromIrq,
  input wire logic sleepExec,
  output logic irqRequest,
  output logic vectorLoad,
  output irl_pkg::irl_pc_t vectorAddr,
  output logic pushReturn,
  output logic insertNop,
  output logic wakeUp,
  output logic sleepAsNop,
  output logic asleep,
  output logic globalIrqEnable
);
  import irl_pkg::*;

  typedef struct packed {
    logic globalIrqEnable;
    logic periphGroupEnable;
    logic timer0OvfEnable;
    logic extPinIrqEnable;
    logic portChangeEnable;
    logic timer0OvfFlag;
    logic extPinIrqFlag;
    irl_byte_t periphFlags;
    irl_byte_t periphEnables;
    logic extEdgeSelect;
    logic pinLast;
    logic [3:0] portLast;
    // Low for one cycle after reset so stale samples give no edge
    logic armed;
    logic [1:0] phase;
    irl_fsm_t fsm;
    logic nopHold;
    logic asleep;
    irl_byte_t rdData;
    logic irqRequest;
    logic vectorLoad;
    logic pushReturn;
    logic wakeUp;
    logic sleepAsNop;
    irl_pc_t vectorAddr;
  } irl_state_t;

  irl_state_t s;
  irl_state_t next_s;
  logic portChangeFlag;
  logic next_portChangeFlag;
  logic ctrlWr;
  logic pflagWr;
  logic penWr;
  logic optWr;
  logic extEdge;
  logic portChange;
  logic pending;
  logic request;

  // Any source with flag and its enable chain set, ignoring global
  function automatic logic anyPending(
    input irl_state_t st,
    input logic port_change_flag
  );
    logic core;
    logic periph;
    core = (st.timer0OvfEnable & st.timer0OvfFlag) |
           (st.extPinIrqEnable & st.extPinIrqFlag) |
           (st.portChangeEnable & port_change_flag);
    periph = st.periphGroupEnable &
             (|(st.periphFlags & st.periphEnables & `IRL_PMASK));
    return core | periph;
  endfunction

  // Hardware set beats a same-cycle software write, so no event is lost
  function automatic logic flagNext(
    input logic cur,
    input logic wr,
    input logic wrBit,
    input logic hit
  );
    logic v;
    v = cur;
    if (wr) begin
      v = wrBit;
    end
    if (hit) begin
      v = 1'b1;
    end
    return v;
  endfunction

  function automatic irl_byte_t readMux(
    input irl_state_t st,
    input logic port_change_flag,
    input logic [7:0] a
  );
    irl_byte_t v;
    v = `IRL_ZERO8;
    if (a == `IRL_OFS_CTRL) begin
      v[`IRL_B_GIE] = st.globalIrqEnable;
      v[`IRL_B_PERIPH_GROUP_ENABLE] = st.periphGroupEnable;
      v[`IRL_B_TIMER0_OVF_ENABLE] = st.timer0OvfEnable;
      v[`IRL_B_EXT_PIN_IRQ_ENABLE] = st.extPinIrqEnable;
      v[`IRL_B_PORT_CHANGE_ENABLE] = st.portChangeEnable;
      v[`IRL_B_TIMER0_OVF_FLAG] = st.timer0OvfFlag;
      v[`IRL_B_EXT_PIN_IRQ_FLAG] = st.extPinIrqFlag;
      v[`IRL_B_PORT_CHANGE_FLAG] = port_change_flag;
    end else if (a == `IRL_OFS_PFLAG) begin
      v = st.periphFlags & `IRL_PMASK;
    end else if (a == `IRL_OFS_PEN) begin
      v = st.periphEnables & `IRL_PMASK;
    end else if (a == `IRL_OFS_OPTION) begin
      v[`IRL_B_EDGE] = st.extEdgeSelect;
    end
    return v;
  endfunction

  // Address decode
  always_comb begin
    ctrlWr = 1'b0;
    pflagWr = 1'b0;
    penWr = 1'b0;
    optWr = 1'b0;
    if (!regWrite) begin
      ctrlWr = 1'b0;
    end else if (regAddr == `IRL_OFS_CTRL) begin
      ctrlWr = 1'b1;
    end else if (regAddr == `IRL_OFS_PFLAG) begin
      pflagWr = 1'b1;
    end else if (regAddr == `IRL_OFS_PEN) begin
      penWr = 1'b1;
    end else if (regAddr == `IRL_OFS_OPTION) begin
      optWr = 1'b1;
    end
  end

  // Rising or falling edge as selected; none in the first cycle out of
  // reset, when the stored level is only the reset constant
  assign extEdge = s.armed &
                   (s.extEdgeSelect ?
                    (extIrqPin & ~s.pinLast) :
                    (~extIrqPin & s.pinLast));

  // A change during a port read is dropped; cheaper than a mismatch latch
  // Pins that sit high through reset must not look like a change
  assign portChange = s.armed &
                      (portUpperPins != s.portLast) &
                      ~portRead;

  assign pending = anyPending(s, portChangeFlag);
  assign request = s.globalIrqEnable & pending;

  // Port flag survives non power-up resets, so it has its own reset
  always_comb begin
    next_portChangeFlag = flagNext(portChangeFlag, ctrlWr,
                                   regWrData[`IRL_B_PORT_CHANGE_FLAG],
                                   portChange);
  end

  always_ff @(posedge core_clk or negedge porRst_n) begin
    if (!porRst_n) begin
      portChangeFlag <= 1'b0;
    end else begin
      portChangeFlag <= next_portChangeFlag;
    end
  end

  always_comb begin
    next_s = s;
    next_s.vectorLoad = 1'b0;
    next_s.pushReturn = 1'b0;
    next_s.wakeUp = 1'b0;
    next_s.sleepAsNop = 1'b0;
    next_s.rdData = `IRL_ZERO8;
    next_s.phase = s.phase + `IRL_PH_STEP;
    next_s.pinLast = extIrqPin;
    next_s.portLast = portUpperPins;
    next_s.irqRequest = request;
    next_s.armed = 1'b1;

    // Software writes first so hardware events below win
    if (ctrlWr) begin
      next_s.globalIrqEnable = regWrData[`IRL_B_GIE];
      next_s.periphGroupEnable = regWrData[`IRL_B_PERIPH_GROUP_ENABLE];
      next_s.timer0OvfEnable = regWrData[`IRL_B_TIMER0_OVF_ENABLE];
      next_s.extPinIrqEnable = regWrData[`IRL_B_EXT_PIN_IRQ_ENABLE];
      next_s.portChangeEnable = regWrData[`IRL_B_PORT_CHANGE_ENABLE];
      if (s.globalIrqEnable && !regWrData[`IRL_B_GIE]) begin
        next_s.nopHold = 1'b1;
      end
    end
    if (pflagWr) begin
      next_s.periphFlags = regWrData & `IRL_PMASK;
    end
    if (penWr) begin
      next_s.periphEnables = regWrData & `IRL_PMASK;
    end
    if (optWr) begin
      next_s.extEdgeSelect = regWrData[`IRL_B_EDGE];
    end

    // Events set flags whatever the enables, and beat a software clear
    next_s.timer0OvfFlag = flagNext(s.timer0OvfFlag, ctrlWr,
                                    regWrData[`IRL_B_TIMER0_OVF_FLAG],
                                    timer0Rollover);
    next_s.extPinIrqFlag = flagNext(s.extPinIrqFlag, ctrlWr,
                                    regWrData[`IRL_B_EXT_PIN_IRQ_FLAG],
                                    extEdge);
    next_s.periphFlags = next_s.periphFlags |
                         (periphEvent & `IRL_PMASK);

    if (returnFromIrq) begin
      next_s.globalIrqEnable = 1'b1;
    end

    // Requests are looked at once per instruction cycle, at Q1
    if (s.phase == `IRL_Q1) begin
      case (s.fsm)
        IRL_IDLE: begin
          if (s.nopHold) begin
            next_s.nopHold = 1'b0;
          end else if (request) begin
            next_s.globalIrqEnable = 1'b0;
            next_s.fsm = IRL_WAIT1;
          end
        end
        IRL_WAIT1: begin
          next_s.fsm = IRL_WAIT2;
        end
        IRL_WAIT2: begin
          next_s.fsm = IRL_VECT;
          next_s.vectorLoad = 1'b1;
          next_s.pushReturn = 1'b1;
          next_s.vectorAddr = `IRL_VECTOR;
        end
        IRL_VECT: begin
          next_s.fsm = IRL_IDLE;
        end
        default: begin
          next_s.fsm = IRL_IDLE;
        end
      endcase
    end else if (s.fsm == IRL_VECT) begin
      next_s.fsm = IRL_IDLE;
    end

    // Sleep entry and wake
    if (sleepExec && !s.asleep) begin
      if (pending) begin
        next_s.sleepAsNop = 1'b1;
      end else begin
        next_s.asleep = 1'b1;
      end
    end
    if (s.asleep && pending) begin
      // Vectoring afterwards is left to the normal Q1 path
      next_s.asleep = 1'b0;
      next_s.wakeUp = 1'b1;
    end

    if (regRead) begin
      next_s.rdData = readMux(s, portChangeFlag, regAddr);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.globalIrqEnable <= 1'b0;
      s.periphGroupEnable <= 1'b0;
      s.timer0OvfEnable <= 1'b0;
      s.extPinIrqEnable <= 1'b0;
      s.portChangeEnable <= 1'b0;
      s.timer0OvfFlag <= 1'b0;
      s.extPinIrqFlag <= 1'b0;
      s.periphFlags <= `IRL_PREG_RST;
      s.periphEnables <= `IRL_PREG_RST;
      s.extEdgeSelect <= `IRL_EDGE_RST;
      s.pinLast <= 1'b0;
      s.portLast <= 4'h0;
      s.armed <= 1'b0;
      s.phase <= `IRL_PH_RST;
      s.fsm <= IRL_IDLE;
      s.nopHold <= 1'b0;
      s.asleep <= 1'b0;
      s.rdData <= `IRL_ZERO8;
      s.irqRequest <= 1'b0;
      s.vectorLoad <= 1'b0;
      s.pushReturn <= 1'b0;
      s.wakeUp <= 1'b0;
      s.sleepAsNop <= 1'b0;
      s.vectorAddr <= `IRL_PC_RST;
    end else begin
      s <= next_s;
    end
  end

  assign regRdData = s.rdData;
  assign irqRequest = s.irqRequest;
  assign vectorLoad = s.vectorLoad;
  assign vectorAddr = s.vectorAddr;
  assign pushReturn = s.pushReturn;
  assign insertNop = s.nopHold;
  assign wakeUp = s.wakeUp;
  assign sleepAsNop = s.sleepAsNop;
  assign asleep = s.asleep;
  assign globalIrqEnable = s.globalIrqEnable;

endmodule // irl_request_logic

// ===== core/irl_regs.svh
// Register offsets, field positions, resets and timing for irq logic
`ifndef IRL_REGS_SVH
`define IRL_REGS_SVH

// Register offsets
`define IRL_OFS_CTRL 8'h0B
`define IRL_OFS_PFLAG 8'h0C
`define IRL_OFS_PEN 8'h8C
`define IRL_OFS_OPTION 8'h81

// Control register fields
`define IRL_B_GIE 7
`define IRL_B_PERIPH_GROUP_ENABLE 6
`define IRL_B_TIMER0_OVF_ENABLE 5
`define IRL_B_EXT_PIN_IRQ_ENABLE 4
`define IRL_B_PORT_CHANGE_ENABLE 3
`define IRL_B_TIMER0_OVF_FLAG 2
`define IRL_B_EXT_PIN_IRQ_FLAG 1
`define IRL_B_PORT_CHANGE_FLAG 0

// Option register field
`define IRL_B_EDGE 6

// Peripheral registers: bit 3 unimplemented
`define IRL_PMASK 8'hF7

// Reset values
`define IRL_PREG_RST 8'h00
`define IRL_EDGE_RST 1'b1
`define IRL_ZERO8 8'h00
`define IRL_PC_RST 13'h0000

// Fixed interrupt vector
`define IRL_VECTOR 13'h0004

// Instruction cycle timing
`define IRL_CLK_PER_TCY 4
`define IRL_Q1 2'h0
`define IRL_PH_STEP 2'h1
`define IRL_PH_RST 2'h0
`define IRL_LAT_TCY 3

`endif

// ===== core/irl_pkg.sv
// Types shared by the interrupt request logic
package irl_pkg;

  // Latency sequencer, Gray along the path
  typedef enum logic [1:0] {
    IRL_IDLE = 2'h0,
    IRL_WAIT1 = 2'h1,
    IRL_WAIT2 = 2'h3,
    IRL_VECT = 2'h2
  } irl_fsm_t;

  typedef logic [7:0] irl_byte_t;
  typedef logic [12:0] irl_pc_t;

endpackage

// ===== tb/irl_monitor.sv
// Port assertions for the interrupt request logic
`timescale 1ns/1ps
module irl_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic regWrite,
  // Core sequencer
  input wire logic returnFromIrq,
  input wire logic sleepExec,
  input wire logic irqRequest,
  input wire logic vectorLoad,
  input wire irl_pkg::irl_pc_t vectorAddr,
  input wire logic pushReturn,
  input wire logic insertNop,
  input wire logic wakeUp,
  input wire logic sleepAsNop,
  input wire logic asleep,
  input wire logic globalIrqEnable
);
  import irl_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_vec_addr: assert property (vectorLoad |-> vectorAddr == 13'h0004)
    else $error("vector address wrong");
  a_push_only_vec: assert property (pushReturn |-> vectorLoad)
    else $error("push without vector");
  a_vec_single_pulse: assert property (
    vectorLoad |-> pushReturn ##1 !vectorLoad && !pushReturn)
    else $error("vector pulse malformed");
  a_accept_then_vec: assert property (
    vectorLoad |-> $past(globalIrqEnable, 9) && !$past(globalIrqEnable, 8))
    else $error("vector not nine cycles after accept");
  a_req_gated: assert property (irqRequest |-> $past(globalIrqEnable))
    else $error("request without global enable");
  a_rfi_sets_gie: assert property (returnFromIrq |=> globalIrqEnable)
    else $error("return did not enable");
  a_nop_cause: assert property (
    $rose(insertNop) |-> $past(regWrite) && !globalIrqEnable)
    else $error("nop without clearing write");
  a_sleep_entry: assert property (
    $rose(asleep) |-> $past(sleepExec) && !sleepAsNop)
    else $error("sleep entered wrongly");
  a_sleep_refused: assert property (
    sleepAsNop |-> !asleep && $past(sleepExec) ##1 !sleepAsNop)
    else $error("sleep refusal malformed");
  a_wake_pulse: assert property (
    wakeUp |-> $past(asleep) && !asleep ##1 !wakeUp)
    else $error("wake pulse malformed");
  c_vector: cover property (vectorLoad);
  c_wake: cover property (wakeUp);
  c_refuse: cover property (sleepAsNop);
  c_nop: cover property (insertNop);
endmodule // irl_monitor

bind irl_request_logic irl_monitor i_mon (.*);

// ===== tb/irl_core_model.sv
// Core sequencer model: counts vectors, returns a delay after retGo
`timescale 1ns/1ps
module irl_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sequencer side
  input wire logic vectorLoad,
  input wire logic retGo,
  input wire logic [3:0] retDelay,
  output logic returnFromIrq,
  output logic [7:0] vecCount
);
  logic [3:0] cnt;
  logic busy;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      busy <= 1'b0;
      returnFromIrq <= 1'b0;
      vecCount <= 8'h00;
    end else begin
      // Slow routines model a long service before return
      returnFromIrq <= busy && cnt == 4'h0;
      if (vectorLoad)
        vecCount <= vecCount + 8'h01;
      if (retGo) begin
        busy <= 1'b1;
        cnt <= retDelay;
      end else if (busy && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else
        busy <= 1'b0;
    end
  end
endmodule // irl_core_model

// ===== tb/tb_irl_request_logic.sv
// Self-checking bench for the interrupt request logic
`timescale 1ns/1ps
module tb_irl_request_logic;
  import irl_pkg::*;
  logic core_clk = 0, rst_n = 0, porRst_n = 0;
  logic [7:0] regAddr = 8'h00, regRdData, periphEvent = 8'h00, e = 8'h00;
  irl_byte_t regWrData = 8'h00;
  logic regWrite = 0, regRead = 0, extIrqPin = 0, timer0Rollover = 0;
  logic portRead = 0, sleepExec = 0, retGo = 0;
  logic [3:0] portUpperPins = 4'h0, retDelay = 4'h0;
  logic returnFromIrq, irqRequest, vectorLoad, pushReturn, insertNop;
  logic wakeUp, sleepAsNop, asleep, globalIrqEnable;
  irl_pc_t vectorAddr;
  logic [7:0] vecCount;
  int n_errors = 0, checks_done = 0, n;
  irl_request_logic i_dut (.*);
  irl_core_model i_core (.*);
  always #5 core_clk = ~core_clk;
  task automatic chk(string what, logic [12:0] exp, logic [12:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {5'h00, exp}, {5'h00, regRdData});
  endtask
  task automatic pin(logic v);
    @(posedge core_clk);
    extIrqPin <= v;
  endtask
  task automatic wait_vec();
    n = 0;
    while (vectorLoad !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task automatic ret_irq(logic [3:0] d);
    @(posedge core_clk);
    retDelay <= d;
    retGo <= 1'b1;
    @(posedge core_clk);
    retGo <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask
  task automatic sleep_cmd();
    @(posedge core_clk);
    sleepExec <= 1'b1;
    @(posedge core_clk);
    sleepExec <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Whole run needs about 250 cycles
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    porRst_n <= 1'b1;
    rd(8'h0B, 8'h00);
    rd(8'h81, 8'h40);
    rd(8'h0C, 8'h00);
    wr(8'h8C, 8'hFF);
    rd(8'h8C, 8'hF7);
    rd(8'h55, 8'h00);
    for (int b = 0; b < 8; b++) begin
      @(posedge core_clk);
      periphEvent <= 8'h01 << b;
      @(posedge core_clk);
      periphEvent <= 8'h00;
      e = e | ((8'h01 << b) & 8'hF7);
      rd(8'h0C, e);
    end
    wr(8'h0C, 8'h00);
    @(posedge core_clk);
    timer0Rollover <= 1'b1;
    @(posedge core_clk);
    timer0Rollover <= 1'b0;
    rd(8'h0B, 8'h04);
    wr(8'h0B, 8'h00);
    @(posedge core_clk);
    portUpperPins <= 4'h4;
    rd(8'h0B, 8'h01);
    // Plain reset keeps the port-change flag
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h0B, 8'h01);
    rd(8'h8C, 8'h00);
    wr(8'h0B, 8'h00);
    @(posedge core_clk);
    portRead <= 1'b1;
    portUpperPins <= 4'h0;
    @(posedge core_clk);
    portRead <= 1'b0;
    rd(8'h0B, 8'h00);
    wr(8'h81, 8'h00);
    pin(1'b1);
    rd(8'h0B, 8'h00);
    pin(1'b0);
    rd(8'h0B, 8'h02);
    wr(8'h81, 8'h40);
    wr(8'h0B, 8'h90);
    pin(1'b1);
    wait_vec();
    chk("latency ok", 1, n >= 8 && n <= 16);
    chk("vector", 13'h0004, vectorAddr);
    chk("push", 1, pushReturn);
    rd(8'h0B, 8'h12);
    wr(8'h0B, 8'h10);
    ret_irq(4'h2);
    rd(8'h0B, 8'h90);
    chk("vectors", 1, vecCount);
    wr(8'h0B, 8'h00);
    #1;
    chk("nop held", 1, insertNop);
    wr(8'h8C, 8'h01);
    wr(8'h0B, 8'h80);
    @(posedge core_clk);
    periphEvent <= 8'h01;
    @(posedge core_clk);
    periphEvent <= 8'h00;
    repeat (20) @(posedge core_clk);
    chk("vectors", 1, vecCount);
    chk("no request", 0, irqRequest);
    wr(8'h0B, 8'hC0);
    @(posedge core_clk);
    #1;
    chk("request", 1, irqRequest);
    wait_vec();
    chk("group vector", 1, n < 40);
    wr(8'h0C, 8'h00);
    ret_irq(4'hC);
    wr(8'h0B, 8'h10);
    pin(1'b0);
    sleep_cmd();
    chk("asleep", 1, asleep);
    pin(1'b1);
    n = 0;
    while (wakeUp !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("woke", 1, n < 10 && asleep === 1'b0);
    repeat (20) @(posedge core_clk);
    chk("vectors", 2, vecCount);
    sleep_cmd();
    chk("sleep refused", 1, sleepAsNop);
    chk("asleep", 0, asleep);
    tally_and_finish();
  end
endmodule // tb_irl_request_logic
